// File: isz_pkg.sv
package isz_pkg;
    // -----------------------------------------------------------------
    // Encoding
    // -----------------------------------------------------------------
    localparam logic [5:0] ISZ_OPCODE = 6'h0F;
    localparam int ISZ_OPC_MSB = 15;
    localparam int ISZ_OPC_LSB = 10;
    localparam int ISZ_DEST_BIT = 9;
    localparam int ISZ_ACC_BIT = 8;
    localparam int ISZ_ADDR_MSB = 7;
    localparam logic [3:0] ISZ_ACCESS_BANK = 4'h0;
    localparam logic [7:0] ISZ_ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ISZ_SFR_BANK = 4'hF;
    localparam logic [20:0] ISZ_PC_STEP = 21'h000001;
    localparam logic [7:0] ISZ_ONE = 8'h01;
    localparam logic [7:0] ISZ_ZERO = 8'h00;
    localparam logic [1:0] ISZ_Q_RESET = 2'h0;
    localparam logic [1:0] ISZ_SKIP_ONE = 2'h1;
    localparam logic [1:0] ISZ_SKIP_TWO = 2'h2;

    typedef enum logic [1:0] {
        Q1_DECODE,
        Q2_READ,
        Q3_PROCESS,
        Q4_WRITE
    } isz_phase_type;
endpackage : isz_pkg

// File: isz_phase_gen.sv
module isz_phase_gen
    import isz_pkg::*;
(
    input wire logic clk,       // Core clock
    input wire logic resetn,    // Async reset, active low
    output isz_phase_type phase // Current quarter phase
);
    isz_phase_type phase_q, phase_d;

    always_comb begin
        case (phase_q)
            Q1_DECODE: phase_d = Q2_READ;
            Q2_READ: phase_d = Q3_PROCESS;
            Q3_PROCESS: phase_d = Q4_WRITE;
            Q4_WRITE: phase_d = Q1_DECODE;
            default: phase_d = Q1_DECODE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= Q1_DECODE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
endmodule : isz_phase_gen

// File: isz_exec.sv
module isz_exec
    import isz_pkg::*;
(
    input wire logic clk,            // Core clock, one quarter phase each
    input wire logic resetn,         // Async reset, active low
    input wire logic instrValid,     // Fetched word is present this cycle
    input wire logic [15:0] instr,   // Instruction word in execution
    input wire logic nextTwoWord,    // Prefetched instruction is two words
    input wire logic [3:0] bankSel,  // bank_select_register value
    input wire logic [7:0] memRdata, // Data memory read data
    input wire logic [20:0] pcIn,    // Program counter of this word
    input wire logic [4:0] flagsIn,  // Arithmetic status flags
    output logic [11:0] memAddr,     // Data memory address
    output logic memRd,              // Read strobe in Q2
    output logic memWr,              // Write strobe in Q4
    output logic [7:0] memWdata,     // Data memory write data
    output logic accWr,              // Accumulator write strobe in Q4
    output logic [7:0] accWdata,     // Accumulator write data
    output logic [4:0] flagsOut,     // Status flags, passed unchanged
    output logic [20:0] pcNext,      // Next program counter
    output logic pcLoad,             // pcNext valid, pulsed in Q4
    output logic discard,            // Prefetched word turned into no-op
    output logic busy,               // Skip cycles running, fetch stalls
    output logic match,              // Current word is this instruction
    output logic [1:0] phaseOut      // Quarter phase number
);
    // -----------------------------------------------------------------
    // Phase
    // -----------------------------------------------------------------
    isz_phase_type phase;

    isz_phase_gen uPhase (
        .clk(clk),
        .resetn(resetn),
        .phase(phase)
    );

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [1:0] skipCnt_q, skipCnt_d;
    logic act_q, act_d;
    logic dest_q, dest_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [20:0] pc_q, pc_d;
    logic [11:0] memAddr_q, memAddr_d;
    logic memRd_q, memRd_d;
    logic memWr_q, memWr_d;
    logic [7:0] memWdata_q, memWdata_d;
    logic accWr_q, accWr_d;
    logic [7:0] accWdata_q, accWdata_d;
    logic [4:0] flags_q, flags_d;
    logic [20:0] pcNext_q, pcNext_d;
    logic pcLoad_q, pcLoad_d;
    logic discard_q, discard_d;
    logic busy_q, busy_d;
    logic match_q, match_d;
    logic [1:0] phase_q, phase_d;
    logic isOp;
    logic [7:0] sum;

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    assign isOp = instrValid
        && instr[ISZ_OPC_MSB:ISZ_OPC_LSB] == ISZ_OPCODE;
    // Eight bits wrap from FF to 00, which is what starts a skip
    assign sum = data_q + ISZ_ONE;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        skipCnt_d = skipCnt_q;
        act_d = act_q;
        dest_d = dest_q;
        addr_d = addr_q;
        data_d = data_q;
        pc_d = pc_q;
        memAddr_d = memAddr_q;
        memRd_d = 1'b0;
        memWr_d = 1'b0;
        memWdata_d = memWdata_q;
        accWr_d = 1'b0;
        accWdata_d = accWdata_q;
        flags_d = flagsIn;
        pcNext_d = pcNext_q;
        pcLoad_d = 1'b0;
        discard_d = discard_q;
        match_d = match_q;
        phase_d = 2'(phase);
        case (phase)
            Q1_DECODE: begin
                discard_d = 1'b0;
                // Skip cycles decode nothing; the word is a no-op
                if (skipCnt_q != ISZ_Q_RESET) begin
                    act_d = 1'b0;
                    match_d = 1'b0;
                end else begin
                    act_d = isOp;
                    match_d = isOp;
                    dest_d = instr[ISZ_DEST_BIT];
                    pc_d = pcIn;
                    // With a=0 the upper half of the fast bank is the top bank
                    if (instr[ISZ_ACC_BIT]) begin
                        addr_d = {bankSel, instr[ISZ_ADDR_MSB:0]};
                    end else if (instr[ISZ_ADDR_MSB:0] < ISZ_ACCESS_SPLIT) begin
                        addr_d = {ISZ_ACCESS_BANK,
                                  instr[ISZ_ADDR_MSB:0]};
                    end else begin
                        addr_d = {ISZ_SFR_BANK, instr[ISZ_ADDR_MSB:0]};
                    end
                end
            end
            Q2_READ: begin
                if (act_q) begin
                    memAddr_d = addr_q;
                    memRd_d = 1'b1;
                end
            end
            Q3_PROCESS: begin
                if (act_q) begin
                    data_d = memRdata;
                end
            end
            Q4_WRITE: begin
                if (act_q) begin
                    if (dest_q) begin
                        memAddr_d = addr_q;
                        memWr_d = 1'b1;
                        memWdata_d = sum;
                    end else begin
                        accWr_d = 1'b1;
                        accWdata_d = sum;
                    end
                    // One word is always consumed, so the step is fixed
                    pcLoad_d = 1'b1;
                    pcNext_d = pc_q + ISZ_PC_STEP;
                    if (sum == ISZ_ZERO) begin
                        discard_d = 1'b1;
                        // Skipped word still occupies the fetch slots
                        skipCnt_d = nextTwoWord ? ISZ_SKIP_TWO
                                                : ISZ_SKIP_ONE;
                    end
                end else if (skipCnt_q != ISZ_Q_RESET) begin
                    // A skip cycle retires at its last quarter phase
                    skipCnt_d = skipCnt_q - ISZ_SKIP_ONE;
                end
            end
            default: begin
                act_d = 1'b0;
            end
        endcase
        // Fetch stays stalled until the last skip cycle has retired
        busy_d = skipCnt_d != ISZ_Q_RESET;
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            skipCnt_q <= ISZ_Q_RESET;
            act_q <= 1'b0;
            dest_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            pc_q <= '0;
            memAddr_q <= '0;
            memRd_q <= 1'b0;
            memWr_q <= 1'b0;
            memWdata_q <= '0;
            accWr_q <= 1'b0;
            accWdata_q <= '0;
            flags_q <= '0;
            pcNext_q <= '0;
            pcLoad_q <= 1'b0;
            discard_q <= 1'b0;
            busy_q <= 1'b0;
            match_q <= 1'b0;
            phase_q <= ISZ_Q_RESET;
        end else begin
            skipCnt_q <= skipCnt_d;
            act_q <= act_d;
            dest_q <= dest_d;
            addr_q <= addr_d;
            data_q <= data_d;
            pc_q <= pc_d;
            memAddr_q <= memAddr_d;
            memRd_q <= memRd_d;
            memWr_q <= memWr_d;
            memWdata_q <= memWdata_d;
            accWr_q <= accWr_d;
            accWdata_q <= accWdata_d;
            flags_q <= flags_d;
            pcNext_q <= pcNext_d;
            pcLoad_q <= pcLoad_d;
            discard_q <= discard_d;
            busy_q <= busy_d;
            match_q <= match_d;
            phase_q <= phase_d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign memAddr = memAddr_q;
    assign memRd = memRd_q;
    assign memWr = memWr_q;
    assign memWdata = memWdata_q;
    assign accWr = accWr_q;
    assign accWdata = accWdata_q;
    assign flagsOut = flags_q;
    assign pcNext = pcNext_q;
    assign pcLoad = pcLoad_q;
    assign discard = discard_q;
    assign busy = busy_q;
    assign match = match_q;
    assign phaseOut = phase_q;
endmodule : isz_exec

// File: isz_exec_properties.sv
module isz_exec_properties
    import isz_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic [15:0] instr, // Word
    input wire logic nextTwoWord, // Long next
    input wire logic [3:0] bankSel, // Bank
    input wire logic [7:0] memRdata, // Read data
    input wire logic [20:0] pcIn, // PC in
    input wire logic [4:0] flagsIn, // Flags in
    input wire logic [11:0] memAddr, // Address
    input wire logic memRd, // Read
    input wire logic memWr, // Write
    input wire logic [7:0] memWdata, // Write data
    input wire logic accWr, // Acc write
    input wire logic [7:0] accWdata, // Acc data
    input wire logic [4:0] flagsOut, // Flags out
    input wire logic [20:0] pcNext, // Next PC
    input wire logic pcLoad, // PC load
    input wire logic discard // Skip
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic quiet;
    logic [7:0] result;
    assign quiet = !(memRd || memWr || accWr || pcLoad);
    assign result = memWr ? memWdata : accWdata;
    // Upper half of the fast bank maps onto the top bank
    function automatic logic [11:0] bankAddr(logic [15:0] w, logic [3:0] b);
        if (w[ISZ_ACC_BIT])
            return {b, w[7:0]};
        return {w[7] ? ISZ_SFR_BANK : ISZ_ACCESS_BANK, w[7:0]};
    endfunction
    sequence oneSkip;
        quiet [*5];
    endsequence
    sequence twoSkip;
        quiet [*8] ##1 quiet;
    endsequence
    wr_follow_a: assert property (memRd |-> ##2 (memWr ^ accWr))
        else $error("no single write after read");
    wr_value_a: assert property (
        memRd |-> ##2 result == $past(memRdata, 2) + ISZ_ONE)
        else $error("write value wrong");
    addr_map_a: assert property (
        memRd |-> memAddr == bankAddr($past(instr, 2), $past(bankSel, 2)))
        else $error("address wrong");
    zero_skip_a: assert property (
        (memWr || accWr) |-> discard == (result == ISZ_ZERO))
        else $error("discard wrong");
    skip_one_a: assert property (
        discard && !$past(nextTwoWord) |=> oneSkip)
        else $error("activity in skip cycle");
    skip_two_a: assert property (
        discard && $past(nextTwoWord) |=> twoSkip)
        else $error("activity in double skip");
    flags_kept_a: assert property (
        $past(resetn) |-> flagsOut == $past(flagsIn))
        else $error("flags altered");
    pc_step_a: assert property (
        pcLoad |-> pcNext == $past(pcIn, 4) + ISZ_PC_STEP)
        else $error("pc step wrong");
endmodule : isz_exec_properties

bind isz_exec isz_exec_properties chk (.clk, .resetn, .instr, .nextTwoWord,
    .bankSel, .memRdata, .pcIn, .flagsIn, .memAddr, .memRd, .memWr,
    .memWdata, .accWr, .accWdata, .flagsOut, .pcNext, .pcLoad, .discard);

// File: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import isz_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic instrValid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic nextTwoWord = 1'b0;
    logic [3:0] bankSel = 4'h0;
    logic [7:0] memRdata = 8'h00;
    logic [20:0] pcIn = 21'h000000;
    logic [4:0] flagsIn = 5'h00;
    logic [11:0] memAddr, nAddr;
    logic memRd, memWr, accWr, pcLoad, discard, busy, match, vld, nBusy;
    logic nHit, nD, nZero, pHit, pD, pZero;
    logic [7:0] memWdata, accWdata, v, nVal, pVal;
    logic [4:0] flagsOut, nF, pF;
    logic [20:0] pcNext, nPc, pPc;
    logic [15:0] w;
    logic [1:0] phaseOut;
    logic [31:0] seed = 32'h00000021;
    int errors = 0;
    int totalChecks = 0;
    int skip = 0;

    always #5 clk = ~clk;

    isz_exec dut (.clk, .resetn, .instrValid, .instr, .nextTwoWord,
        .bankSel, .memRdata, .pcIn, .flagsIn, .memAddr, .memRd, .memWr,
        .memWdata, .accWr, .accWdata, .flagsOut, .pcNext, .pcLoad,
        .discard, .busy, .match, .phaseOut);

    function automatic logic [31:0] xorshift(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xorshift

    // Twelve-bit data address of a word under a given bank select value
    function automatic logic [11:0] expAddr(logic [15:0] x, logic [3:0] b);
        if (x[ISZ_ACC_BIT])
            return {b, x[7:0]};
        return {x[7] ? ISZ_SFR_BANK : ISZ_ACCESS_BANK, x[7:0]};
    endfunction : expAddr

    task automatic chk(logic [20:0] got, logic [20:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask : chk

    task wrap_up;
        if (errors == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // -------------------------------------------------------------------
    // Main sequence: one word per four clocks; results of a word's last
    // quarter phase are checked at the falling edge after they settle
    // -------------------------------------------------------------------
    initial begin
        {pHit, pD, pZero, pF} = 8'h00;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // The last pass sends no word, so the final results are seen
        for (int i = 0; i < 201; i++) begin
            seed = xorshift(seed);
            // Early words are all valid ISZ words; every fourth value wraps to zero
            vld = i < 200 && (i < 16 || seed[31:29] != 3'h0);
            w = {(i < 16 || seed[28]) ? ISZ_OPCODE : seed[27:22], seed[9:0]};
            v = (i % 4 == 0) ? 8'hFF : seed[21:14];
            instrValid <= vld;
            instr <= w;
            memRdata <= v;
            bankSel <= seed[13:10];
            nextTwoWord <= seed[27];
            pcIn <= seed[20:0];
            flagsIn <= seed[4:0];
            nF = seed[4:0];
            nPc = seed[20:0] + ISZ_PC_STEP;
            nBusy = skip != 0;
            nHit = vld && w[15:10] == ISZ_OPCODE && skip == 0;
            nAddr = expAddr(w, seed[13:10]);
            nD = w[ISZ_DEST_BIT];
            nVal = v + ISZ_ONE;
            nZero = nVal == ISZ_ZERO;
            if (skip > 0)
                skip--;
            if (nHit && nZero)
                skip = seed[27] ? 2 : 1;
            @(negedge clk);
            chk(busy, nBusy);
            chk(match, pHit);
            chk(memWr, pHit && pD);
            chk(accWr, pHit && !pD);
            chk(discard, pHit && pZero);
            chk(flagsOut, pF);
            if (pHit) begin
                chk(pD ? memWdata : accWdata, pVal);
                chk(pcNext, pPc);
            end
            {pHit, pD, pZero, pVal, pPc, pF} =
                {nHit, nD, nZero, nVal, nPc, nF};
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(memRd, nHit);
            chk(phaseOut, 2'h1);
            if (nHit)
                chk(memAddr, nAddr);
            repeat (2) @(posedge clk);
        end
        wrap_up;
    end

    initial begin
        #((10 + 201 * 4) * 10 + 500);
        errors++;
        wrap_up;
    end
endmodule : testbench
